// ===== verilog/sqc_queue_ctrl.sv
// sample queue control, threshold and interrupt status logic
`timescale 1ns/1ps
`include "sqc_defs.svh"
// Function
// - control bit 0 enables the empty interrupt, default off
// - control bit 1 enables the full interrupt, default off
// - control bit 2 enables the threshold interrupt, default off
// - combine bit 0: motion on line one, queue events on line two
// - combine bit 1: everything on line one, line two held inactive
// - writing clear bit resets pointers, count and status flags, keeps stored samples
// - enable bit 1 runs the queue; 0 stops all queue operations
// - normal mode accepts samples while free space remains
// - watermark mode drops samples once count reaches the threshold
// - threshold register holds a five bit level in bits 4:0
// - threshold level resets to sixteen samples
// - threshold bits 7:5 always read as zero
// - status bit 0 shows a pending empty interrupt
// - status bit 1 shows a pending full interrupt
// - status bit 2 shows a pending threshold interrupt
// - a queue event is flagged only while its enable bit is set
// - status bits 7:3 always read as zero
// - queue filling advances only on output data rate ticks
module sqc_queue_ctrl
(
  input wire logic clk,
  input wire logic rst,
  input wire sqc_pkg::sqc_reg_req_type reg_req,
  output logic [`SQC_REG_W-1:0] reg_rdata,
  input wire logic odr_tick,
  input wire sqc_pkg::sqc_sample_type sample_in,
  input wire logic sample_pop,
  output logic [`SQC_DATA_W-1:0] sample_out,
  output logic sample_out_valid,
  output logic [`SQC_CNT_W-1:0] queue_count,
  input wire logic motion_irq,
  output logic irq_line_one_n,
  output logic irq_line_two_n
);
  import sqc_pkg::*;

  logic [6:0] ctrl_r;
  logic [6:0] ctrl_nxt;
  logic [`SQC_THR_W-1:0] thr_r;
  logic [`SQC_THR_W-1:0] thr_nxt;
  logic [`SQC_CNT_W-1:0] count_r;
  logic [`SQC_CNT_W-1:0] count_nxt;
  logic [`SQC_CNT_W-1:0] count_inc;
  logic [`SQC_CNT_W-1:0] count_dec;
  logic [`SQC_CNT_W-1:0] limit_nxt;
  logic [`SQC_PTR_W-1:0] wptr_r;
  logic [`SQC_PTR_W-1:0] wptr_nxt;
  logic [`SQC_PTR_W-1:0] rptr_r;
  logic [`SQC_PTR_W-1:0] rptr_nxt;
  logic [`SQC_FLAG_W-1:0] pend_r;
  logic [`SQC_FLAG_W-1:0] pend_nxt;
  logic [`SQC_FLAG_W-1:0] cond;
  logic [`SQC_FLAG_W-1:0] irq_en;
  logic [`SQC_REG_W-1:0] rdata_r;
  logic [`SQC_REG_W-1:0] rdata_nxt;
  logic [`SQC_REG_W-1:0] rd_mux;
  logic line_one_n_r;
  logic line_one_n_nxt;
  logic line_two_n_r;
  logic line_two_n_nxt;
  logic out_valid_r;
  sqc_qstate_type state_r;
  sqc_qstate_type state_nxt;

  wire ctrl_sel = (reg_req.addr == `SQC_ADDR_CTRL);
  wire thr_sel = (reg_req.addr == `SQC_ADDR_THR);
  wire stat_sel = (reg_req.addr == `SQC_ADDR_STAT);
  wire ctrl_wr = reg_req.wr & ctrl_sel;
  wire thr_wr = reg_req.wr & thr_sel;
  wire clr = ctrl_wr & reg_req.wdata[`SQC_BIT_CLR];
  wire qen = ctrl_r[`SQC_BIT_EN];
  wire mode = ctrl_r[`SQC_BIT_MODE];
  wire comb = ctrl_r[`SQC_BIT_COMB];
  wire qen_nxt = ctrl_nxt[`SQC_BIT_EN];
  wire mode_nxt = ctrl_nxt[`SQC_BIT_MODE];
  wire any_pend = |pend_r;

  // control bits; clear is a write pulse and is never stored
  assign ctrl_nxt = ctrl_wr ?
    {reg_req.wdata[`SQC_BIT_MODE:`SQC_BIT_EN], 1'b0,
     reg_req.wdata[`SQC_BIT_COMB:0]} : ctrl_r;
  assign thr_nxt = thr_wr ? reg_req.wdata[`SQC_THR_W-1:0] : thr_r;
  assign irq_en = ctrl_r[`SQC_BIT_TH_EN:`SQC_BIT_EMPTY_EN];

  // push only on a rate tick while the queue is filling
  wire push_ok = odr_tick & sample_in.valid & (state_r == QS_FILL) &
    ~clr;
  wire pop_ok = sample_pop & qen & (count_r != '0) & ~clr;

  assign count_inc = count_r + 6'h01;
  assign count_dec = count_r - 6'h01;
  assign count_nxt = clr ? '0 :
    (push_ok & ~pop_ok) ? count_inc :
    (pop_ok & ~push_ok) ? count_dec : count_r;
  assign wptr_nxt = clr ? '0 : push_ok ? wptr_r + 5'h01 : wptr_r;
  assign rptr_nxt = clr ? '0 : pop_ok ? rptr_r + 5'h01 : rptr_r;

  // watermark mode stops at the threshold, normal mode at full depth
  assign limit_nxt = mode_nxt ? {1'b0, thr_nxt} : `SQC_DEPTH;
  wire at_limit = (count_nxt >= limit_nxt);

  always_comb
  begin
    state_nxt = QS_OFF;
    case (state_r)
      QS_OFF:
      begin
        if (qen_nxt)
        begin
          state_nxt = at_limit ? QS_STOP : QS_FILL;
        end
      end
      QS_FILL:
      begin
        if (!qen_nxt)
        begin
          state_nxt = QS_OFF;
        end
        else if (at_limit)
        begin
          state_nxt = QS_STOP;
        end
        else
        begin
          state_nxt = QS_FILL;
        end
      end
      QS_STOP:
      begin
        if (!qen_nxt)
        begin
          state_nxt = QS_OFF;
        end
        else if (!at_limit)
        begin
          state_nxt = QS_FILL;
        end
        else
        begin
          state_nxt = QS_STOP;
        end
      end
      default:
      begin
        state_nxt = QS_OFF;
      end
    endcase
  end

  // event conditions from the stored count
  assign cond[`SQC_FLAG_EMPTY] = (count_r == '0);
  assign cond[`SQC_FLAG_FULL] = (count_r == `SQC_DEPTH);
  assign cond[`SQC_FLAG_TH] = (count_r >= {1'b0, thr_r});

  genvar k;
  generate
    for (k = 0; k < `SQC_FLAG_W; k = k + 1)
    begin : g_flag
      // level flags follow their condition, gated by enables
      assign pend_nxt[k] = qen & irq_en[k] & cond[k] & ~clr;
    end
  endgenerate

  // line routing; lines are active low
  assign line_one_n_nxt = ~(motion_irq | (comb & any_pend));
  assign line_two_n_nxt = ~(~comb & any_pend);

  // register read mux; unmapped addresses read zero
  assign rd_mux = ctrl_sel ? {1'b0, ctrl_r} :
    thr_sel ? {3'b000, thr_r} :
    stat_sel ? {5'b00000, pend_r} :
    `SQC_ADDR_DEFAULT_RD;
  assign rdata_nxt = reg_req.rd ? rd_mux : rdata_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= `SQC_CTRL_RST;
      thr_r <= `SQC_THR_RST;
      state_r <= QS_OFF;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      thr_r <= thr_nxt;
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= '0;
      wptr_r <= '0;
      rptr_r <= '0;
      out_valid_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      out_valid_r <= pop_ok;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_r <= `SQC_STAT_RST;
      line_one_n_r <= 1'b1;
      line_two_n_r <= 1'b1;
      rdata_r <= '0;
    end
    else
    begin
      pend_r <= pend_nxt;
      line_one_n_r <= line_one_n_nxt;
      line_two_n_r <= line_two_n_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  sqc_sample_mem u_mem
  (
    .clk(clk),
    .rst(rst),
    .wr_en(push_ok),
    .wr_addr(wptr_r),
    .wr_data(sample_in.data),
    .rd_en(pop_ok),
    .rd_addr(rptr_r),
    .rd_data(sample_out)
  );

  assign reg_rdata = rdata_r;
  assign sample_out_valid = out_valid_r;
  assign queue_count = count_r;
  assign irq_line_one_n = line_one_n_r;
  assign irq_line_two_n = line_two_n_r;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_push_try;
    odr_tick && sample_in.valid && !sample_pop && !clr;
  endsequence

  sequence s_room_normal;
    qen && !mode && (count_r < `SQC_DEPTH) && (state_r == QS_FILL);
  endsequence

  sequence s_watermark_hit;
    qen && mode && (count_r >= {1'b0, thr_r});
  endsequence

  AST_EMPTY_PEND:
    assert property ((qen && irq_en[0] && count_r == '0 && !clr)
      |=> pend_r[`SQC_FLAG_EMPTY])
    else $error("empty flag missing");

  AST_FULL_PEND:
    assert property ((qen && irq_en[1] && count_r == `SQC_DEPTH && !clr)
      |=> pend_r[`SQC_FLAG_FULL])
    else $error("full flag missing");

  AST_TH_PEND:
    assert property ((qen && irq_en[2] && count_r >= {1'b0, thr_r} && !clr)
      |=> pend_r[`SQC_FLAG_TH])
    else $error("threshold flag missing");

  AST_GATED_BY_ENABLE:
    assert property (1'b1 |=> ((pend_r & ~$past(irq_en)) == '0))
    else $error("flag set without its enable");

  AST_FLAG_SELF_CLEAR:
    assert property ((count_r != '0 || !qen) |=> !pend_r[`SQC_FLAG_EMPTY])
    else $error("empty flag stuck");

  AST_CLEAR_PTRS:
    assert property (clr |=> (count_r == '0) && (wptr_r == '0) &&
      (rptr_r == '0) && (pend_r == '0))
    else $error("clear left pointers");

  AST_DISABLED_HOLD:
    assert property ((!qen && !ctrl_wr) |=> $stable(count_r) &&
      $stable(wptr_r) && $stable(rptr_r) && !sample_out_valid)
    else $error("disabled queue moved");

  AST_NORMAL_FILL:
    assert property ((s_push_try and s_room_normal)
      |=> count_r == $past(count_r) + 6'h01)
    else $error("normal mode refused a sample");

  AST_WATERMARK_DROP:
    assert property ((s_push_try and s_watermark_hit)
      |=> count_r == $past(count_r))
    else $error("watermark mode accepted a sample");

  AST_ODR_ONLY:
    assert property ((!odr_tick && !clr) |=> count_r <= $past(count_r))
    else $error("queue filled without a rate tick");

  AST_SPLIT_LINES:
    assert property ((!comb && any_pend && !motion_irq) |=>
      !irq_line_two_n && irq_line_one_n)
    else $error("split routing wrong");

  AST_COMBINED_LINES:
    assert property ((comb && any_pend) |=> !irq_line_one_n &&
      irq_line_two_n)
    else $error("combined routing wrong");

  AST_LINE_IDLE:
    assert property ((!any_pend && !motion_irq) |=> irq_line_one_n &&
      irq_line_two_n)
    else $error("line low with nothing pending");

  AST_THR_RESERVED:
    assert property ((reg_req.rd && thr_sel) |=> reg_rdata[7:5] == 3'h0 &&
      reg_rdata[4:0] == $past(thr_r))
    else $error("threshold readback wrong");

  AST_STAT_RESERVED:
    assert property ((reg_req.rd && stat_sel) |=> reg_rdata[7:3] == 5'h00 &&
      reg_rdata[2:0] == $past(pend_r))
    else $error("status readback wrong");

endmodule

// ===== verilog/sqc_defs.svh
// constants for the sample queue control block
`ifndef SQC_DEFS_SVH
`define SQC_DEFS_SVH

`define SQC_REG_W 8
`define SQC_ADDR_CTRL 8'h2D
`define SQC_ADDR_THR 8'h2E
`define SQC_ADDR_STAT 8'h2F
`define SQC_ADDR_DEFAULT_RD 8'h00

`define SQC_CTRL_RST 7'h00
`define SQC_THR_RST 5'h10
`define SQC_STAT_RST 3'h0

`define SQC_BIT_EMPTY_EN 0
`define SQC_BIT_FULL_EN 1
`define SQC_BIT_TH_EN 2
`define SQC_BIT_COMB 3
`define SQC_BIT_CLR 4
`define SQC_BIT_EN 5
`define SQC_BIT_MODE 6

`define SQC_FLAG_EMPTY 0
`define SQC_FLAG_FULL 1
`define SQC_FLAG_TH 2
`define SQC_FLAG_W 3

`define SQC_THR_W 5
`define SQC_PTR_W 5
`define SQC_CNT_W 6
`define SQC_DEPTH 6'h20
`define SQC_DATA_W 48

`endif

// ===== verilog/sqc_pkg.sv
// types shared by the sample queue control block
`include "sqc_defs.svh"
package sqc_pkg;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [`SQC_REG_W-1:0] addr;
    logic [`SQC_REG_W-1:0] wdata;
  } sqc_reg_req_type;

  typedef struct packed
  {
    logic valid;
    logic [`SQC_DATA_W-1:0] data;
  } sqc_sample_type;

  typedef enum logic [2:0]
  {
    QS_OFF = 3'b001,
    QS_FILL = 3'b010,
    QS_STOP = 3'b100
  } sqc_qstate_type;

endpackage

// ===== verilog/sqc_sample_mem.sv
// sample storage for the queue, registered read data
`timescale 1ns/1ps
`include "sqc_defs.svh"
module sqc_sample_mem
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [`SQC_PTR_W-1:0] wr_addr,
  input wire logic [`SQC_DATA_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [`SQC_PTR_W-1:0] rd_addr,
  output logic [`SQC_DATA_W-1:0] rd_data
);
  import sqc_pkg::*;

  logic [`SQC_DATA_W-1:0] mem_r [0:(1<<`SQC_PTR_W)-1];
  logic [`SQC_DATA_W-1:0] rd_data_r;

  // array has no reset, so a queue clear never touches stored samples
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_r <= '0;
    end
    else if (rd_en)
    begin
      rd_data_r <= mem_r[rd_addr];
    end
  end

  assign rd_data = rd_data_r;

endmodule

// ===== testbench/sqc_host_model.sv
// host-side register port model for the sample queue control block
`timescale 1ns/1ps
module sqc_host_model
(
  input wire logic clk,
  output sqc_pkg::sqc_reg_req_type reg_req
);
  import sqc_pkg::*;

  initial reg_req = '0;

  // one write strobe; bit 7 of the control byte is always sent as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a,
      wdata: (a == 8'h2D) ? (d & 8'h7F) : d};
    @(negedge clk);
    reg_req <= '0;
  endtask

  // one read strobe; data stands after the edge that took it
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    reg_req <= '0;
  endtask
endmodule

// ===== testbench/sample_queue_control_test.sv
// self-checking bench for the sample queue control block
`timescale 1ns/1ps
`include "sqc_defs.svh"
module sample_queue_control_test;
  import sqc_pkg::*;
  typedef struct packed
  {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } sqc_row_type;
  logic clk;
  logic rst;
  sqc_reg_req_type reg_req;
  logic [7:0] reg_rdata;
  logic odr_tick;
  sqc_sample_type sample_in;
  logic sample_pop;
  logic [47:0] sample_out;
  logic sample_out_valid;
  logic [5:0] queue_count;
  logic motion_irq;
  logic irq_line_one_n;
  logic irq_line_two_n;
  int mismatches;
  int samples_checked;
  logic [47:0] seq;
  sqc_row_type rows [8] = '{
    '{1'b0, 8'h2D, 8'h00, 8'h00},
    '{1'b0, 8'h2E, 8'h00, 8'h10},
    '{1'b0, 8'h2F, 8'h00, 8'h00},
    '{1'b1, 8'h2E, 8'hFF, 8'h1F},
    '{1'b1, 8'h2E, 8'h04, 8'h04},
    '{1'b1, 8'h2F, 8'hFF, 8'h00},
    '{1'b1, 8'h40, 8'hAA, 8'h00},
    '{1'b1, 8'h2D, 8'hBF, 8'h2F}
  };

  sqc_host_model host
  (
    .clk(clk),
    .reg_req(reg_req)
  );

  sqc_queue_ctrl dut_u
  (
    .clk(clk),
    .rst(rst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .odr_tick(odr_tick),
    .sample_in(sample_in),
    .sample_pop(sample_pop),
    .sample_out(sample_out),
    .sample_out_valid(sample_out_valid),
    .queue_count(queue_count),
    .motion_irq(motion_irq),
    .irq_line_one_n(irq_line_one_n),
    .irq_line_two_n(irq_line_two_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [47:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  task automatic chkreg(input logic [7:0] a, input logic [7:0] e);
    repeat (3) @(negedge clk);
    host.rd(a);
    chk("reg_rdata", {40'h0, e}, {40'h0, reg_rdata});
  endtask

  task automatic push(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      odr_tick <= 1'b1;
      sample_in <= '{valid: 1'b1, data: seq};
      seq++;
    end
    @(negedge clk);
    odr_tick <= 1'b0;
    sample_in.valid <= 1'b0;
  endtask

  // one sample per pop; several samples are never drained at once
  task automatic pop();
    @(negedge clk);
    sample_pop <= 1'b1;
    @(negedge clk);
    sample_pop <= 1'b0;
  endtask

  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    odr_tick = 1'b0;
    sample_in = '0;
    sample_pop = 1'b0;
    motion_irq = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    seq = 48'h100;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        host.wr(rows[i].a, rows[i].d);
      chkreg(rows[i].a, rows[i].e);
    end
    chkreg(8'h2F, 8'h01);
    chk("line_one", 48'h0, {47'h0, irq_line_one_n});
    chk("line_two", 48'h1, {47'h0, irq_line_two_n});
    host.wr(8'h2D, 8'h27);
    chkreg(8'h2D, 8'h27);
    chk("line_one", 48'h1, {47'h0, irq_line_one_n});
    chk("line_two", 48'h0, {47'h0, irq_line_two_n});
    motion_irq <= 1'b1;
    repeat (3) @(negedge clk);
    chk("line_one", 48'h0, {47'h0, irq_line_one_n});
    motion_irq <= 1'b0;
    sample_in <= '{valid: 1'b1, data: 48'hF};
    @(negedge clk);
    sample_in.valid <= 1'b0;
    chk("count", 48'h0, {42'h0, queue_count});
    push(4);
    chk("count", 48'h4, {42'h0, queue_count});
    chkreg(8'h2F, 8'h04);
    push(29);
    chk("count", 48'h20, {42'h0, queue_count});
    chkreg(8'h2F, 8'h06);
    pop();
    chk("sample_out", 48'h100, sample_out);
    chk("out_valid", 48'h1, {47'h0, sample_out_valid});
    chk("count", 48'h1F, {42'h0, queue_count});
    host.wr(8'h2D, 8'h37);
    chk("count", 48'h0, {42'h0, queue_count});
    chkreg(8'h2F, 8'h01);
    host.wr(8'h2D, 8'h60);
    push(6);
    chk("count", 48'h4, {42'h0, queue_count});
    chkreg(8'h2F, 8'h00);
    host.wr(8'h2D, 8'h00);
    push(1);
    chk("count", 48'h4, {42'h0, queue_count});
    pop();
    chk("out_valid", 48'h0, {47'h0, sample_out_valid});
    chkreg(8'h2F, 8'h00);
    // mid-run reset with the queue running and a flag pending
    host.wr(8'h2D, 8'h2C);
    chkreg(8'h2F, 8'h04);
    chk("line_one", 48'h0, {47'h0, irq_line_one_n});
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("line_one", 48'h1, {47'h0, irq_line_one_n});
    chk("line_two", 48'h1, {47'h0, irq_line_two_n});
    chk("count", 48'h0, {42'h0, queue_count});
    chkreg(8'h2D, 8'h00);
    chkreg(8'h2E, 8'h10);
    chkreg(8'h2F, 8'h00);
    end_sim();
  end
endmodule
